//--- core/tbi_pkg.sv
// package: register map, field layout, reset values and state types
package tbi_pkg;

  // =====================================================================
  // register byte offsets
  localparam logic [7:0] TBI_OFS_PSC0   = 8'h00;
  localparam logic [7:0] TBI_OFS_PSC1   = 8'h04;
  localparam logic [7:0] TBI_OFS_CTL0   = 8'h08;
  localparam logic [7:0] TBI_OFS_CTL1   = 8'h0C;
  localparam logic [7:0] TBI_OFS_IRQEN  = 8'h10;
  localparam logic [7:0] TBI_OFS_IRQFLG = 8'h14;

  // =====================================================================
  // field positions
  localparam int TBI_SRC_LSB   = 0;
  localparam int TBI_ON_BIT    = 7;
  localparam int TBI_PER_LSB   = 0;
  localparam int TBI_GIE_BIT   = 0;
  localparam int TBI_ENA0_BIT  = 1;
  localparam int TBI_ENA1_BIT  = 2;
  localparam int TBI_SERE_BIT  = 3;
  localparam int TBI_MFE_BIT   = 4;
  localparam int TBI_FLG0_BIT  = 0;
  localparam int TBI_FLG1_BIT  = 1;
  localparam int TBI_SERF_BIT  = 2;
  localparam int TBI_MFF_BIT   = 3;

  // =====================================================================
  // reset values and encodings
  localparam logic [7:0]  TBI_RST_REG    = 8'h00;
  localparam logic [1:0]  TBI_SRC_SYS    = 2'h0;
  localparam logic [1:0]  TBI_SRC_SYS4   = 2'h1;
  localparam logic [1:0]  TBI_DIV4_LAST  = 2'h3;
  localparam logic [2:0]  TBI_PER_MAX    = 3'h7;
  localparam logic [14:0] TBI_CNT_FULL   = 15'h7FFF;

  // =====================================================================
  // state types
  typedef enum logic [1:0] {TBI_VEC_TICK0, TBI_VEC_TICK1, TBI_VEC_MF}
    tbi_vec_e;

  typedef struct packed {
    logic [1:0]  div;
    logic [14:0] cnt;
    logic        ovf;
  } tbi_pre_s;

  typedef struct packed {
    logic [1:0]  psc0;
    logic [1:0]  psc1;
    logic        tb0_on;
    logic [2:0]  tb0_per;
    logic        tb1_on;
    logic [2:0]  tb1_per;
    logic        gie;
    logic        tb0_en;
    logic        tb1_en;
    logic        ser_en;
    logic        mf_en;
    logic        f0;
    logic        f1;
    logic        fser;
    logic        fmf;
    logic [31:0] prdata;
    logic        irq_req;
    tbi_vec_e    irq_vec;
    logic        wake;
    logic        sub_s1;
    logic        sub_s2;
    logic        sub_s3;
    logic        sub_lvl;
    logic        sub_tick;
  } tbi_top_s;

endpackage

//--- core/tbi_prescale.sv
// module: prescaler source select and one time base counter
`timescale 1ns/100ps
`default_nettype none
module tbi_prescale
  import tbi_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       on,
  input  wire logic [1:0] src_sel,
  input  wire logic [2:0] period_sel,
  input  wire logic       sub_tick,
  output logic            overflow
);

  tbi_pre_s st;
  tbi_pre_s next_st;
  logic     tick;
  logic [14:0] mask;

  // mask of the low 8+k counter bits
  function automatic logic [14:0] tbi_period_mask(input logic [2:0] k);
    tbi_period_mask = TBI_CNT_FULL >> (TBI_PER_MAX - k);
  endfunction

  // =====================================================================
  // source select, count and wrap
  always_comb begin
    next_st     = st;
    next_st.div = st.div + 2'h1;
    next_st.ovf = 1'b0;
    mask        = tbi_period_mask(period_sel);
    // prescaled clock enable
    if (src_sel[1]) begin // R1
      tick = sub_tick;
    end else if (src_sel == TBI_SRC_SYS4) begin
      tick = (st.div == TBI_DIV4_LAST);
    end else begin
      tick = 1'b1;
    end
    if (!on) begin
      next_st.cnt = '0; // R19
    end else if (tick) begin
      if ((st.cnt & mask) == mask) begin
        next_st.cnt = '0; // R2 R3
        next_st.ovf = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 15'h0001; // R19
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign overflow = st.ovf;

  // =====================================================================
  // assertions
  off_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !on |=> st.cnt == 15'h0000 && !st.ovf) // R19
    else $error("disabled time base still counts");
  period_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    on && tick && (st.cnt & mask) == mask |=> st.ovf) // R2
    else $error("no overflow at selected period");
  div4_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    on && src_sel == TBI_SRC_SYS4 && st.div != TBI_DIV4_LAST
    |=> st.cnt == $past(st.cnt)) // R1
    else $error("divide-by-four source counted early");
  ovf_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.ovf |-> $past(on) && $past(st.cnt) != 15'h0000) // R3
    else $error("overflow without full count");

endmodule // tbi_prescale
`default_nettype wire

//--- core/tbi_top.sv
// module: time base interrupt logic with APB register slave
//
// What this block does
// R1 - source select: sys, sys/4, or sub
// R2 - tick0 period is 2^(8+k) clocks
// R3 - tick1 uses its own period field, same 2^(8+k) rule
// R4 - control bit 7 enables, resets zero
// R5 - overflow sets its own request flag
// R6 - tick vector needs enables, flag, stack room
// R7 - tick service clears flag and global enable
// R8 - serial byte done sets serial flag
// R9 - serial vector needs three enables, stack room
// R10 - serial service clears only multifunction flag, gie
// R11 - rising request flag wakes, ignoring enables
// R12 - software presets flag to block wakeup
// R13 - set flag stays until service or clear
// R14 - interrupt entry pushes program counter only
// R15 - interrupt return sets global enable
// R16 - plain return leaves global enable alone
// R17 - software avoids calls inside service routines
// R18 - unused control bits read as zero
// R19 - enabled base counts and wraps; off clears
`timescale 1ns/100ps
`default_nettype none
module tbi_top
  import tbi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sub_clock,
  input  wire logic        serial_byte_done,
  input  wire logic        stack_full,
  input  wire logic        irq_ack,
  input  wire logic        return_from_interrupt,
  output logic             irq_req,
  output tbi_vec_e         irq_vector,
  output logic             push_pc,
  output logic             wake_request,
  output logic             global_irq_enable
);

  tbi_top_s    st;
  tbi_top_s    next_st;
  logic        ovf0;
  logic        ovf1;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr;
  logic        wr_flags;
  logic        wr_en;
  logic        svc;
  logic        svc0;
  logic        svc1;
  logic        svcmf;
  logic        pend0;
  logic        pend1;
  logic        pendmf;
  logic [3:0]  cur_flags;
  logic [3:0]  nxt_flags;
  logic [31:0] rd_val;

  // address decode shared by write and error paths
  function automatic logic tbi_is_mapped(input logic [7:0] a);
    tbi_is_mapped = (a == TBI_OFS_PSC0) || (a == TBI_OFS_PSC1) ||
                    (a == TBI_OFS_CTL0) || (a == TBI_OFS_CTL1) ||
                    (a == TBI_OFS_IRQEN) || (a == TBI_OFS_IRQFLG);
  endfunction

  // =====================================================================
  // time base counters
  tbi_prescale u_tick0 (
    .pclk       (pclk),
    .presetn    (presetn),
    .on         (st.tb0_on),
    .src_sel    (st.psc0),
    .period_sel (st.tb0_per),
    .sub_tick   (st.sub_tick),
    .overflow   (ovf0)
  );

  tbi_prescale u_tick1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .on         (st.tb1_on),
    .src_sel    (st.psc1),
    .period_sel (st.tb1_per),
    .sub_tick   (st.sub_tick),
    .overflow   (ovf1)
  );

  // =====================================================================
  // bus phase and service decode
  always_comb begin
    setup    = psel && !penable;
    access   = psel && penable;
    mapped   = tbi_is_mapped(paddr);
    wr       = access && pwrite && mapped;
    wr_flags = wr && (paddr == TBI_OFS_IRQFLG);
    wr_en    = wr && (paddr == TBI_OFS_IRQEN);
    svc      = irq_ack && st.irq_req;
    svc0     = svc && (st.irq_vec == TBI_VEC_TICK0);
    svc1     = svc && (st.irq_vec == TBI_VEC_TICK1);
    svcmf    = svc && (st.irq_vec == TBI_VEC_MF);
    // vectoring conditions
    pend0  = st.gie && st.tb0_en && st.f0 && !stack_full; // R6
    pend1  = st.gie && st.tb1_en && st.f1 && !stack_full; // R6
    pendmf = st.gie && st.ser_en && st.mf_en && st.fmf &&
             !stack_full; // R9
  end

  // =====================================================================
  // read mux, unused bits read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      TBI_OFS_PSC0: rd_val[1:0] = st.psc0;
      TBI_OFS_PSC1: rd_val[1:0] = st.psc1;
      TBI_OFS_CTL0: begin
        rd_val[TBI_ON_BIT] = st.tb0_on; // R18
        rd_val[2:0]        = st.tb0_per;
      end
      TBI_OFS_CTL1: begin
        rd_val[TBI_ON_BIT] = st.tb1_on; // R18
        rd_val[2:0]        = st.tb1_per;
      end
      TBI_OFS_IRQEN: begin
        rd_val[TBI_GIE_BIT]  = st.gie;
        rd_val[TBI_ENA0_BIT] = st.tb0_en;
        rd_val[TBI_ENA1_BIT] = st.tb1_en;
        rd_val[TBI_SERE_BIT] = st.ser_en;
        rd_val[TBI_MFE_BIT]  = st.mf_en;
      end
      TBI_OFS_IRQFLG: begin
        rd_val[TBI_FLG0_BIT] = st.f0;
        rd_val[TBI_FLG1_BIT] = st.f1;
        rd_val[TBI_SERF_BIT] = st.fser;
        rd_val[TBI_MFF_BIT]  = st.fmf;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // =====================================================================
  // next state
  always_comb begin
    next_st = st;

    // sub clock synchroniser, level taken once stages agree
    next_st.sub_s1   = sub_clock;
    next_st.sub_s2   = st.sub_s1;
    next_st.sub_s3   = st.sub_s2;
    next_st.sub_tick = 1'b0;
    if (st.sub_s2 == st.sub_s3) begin
      next_st.sub_lvl  = st.sub_s3;
      next_st.sub_tick = st.sub_s3 && !st.sub_lvl;
    end

    // read data latched in the setup phase
    if (setup && !pwrite) begin
      next_st.prdata = rd_val;
    end

    // configuration writes
    if (wr) begin
      unique case (paddr)
        TBI_OFS_PSC0: next_st.psc0 = pwdata[TBI_SRC_LSB +: 2]; // R1
        TBI_OFS_PSC1: next_st.psc1 = pwdata[TBI_SRC_LSB +: 2]; // R1
        TBI_OFS_CTL0: begin
          next_st.tb0_on  = pwdata[TBI_ON_BIT]; // R4
          next_st.tb0_per = pwdata[TBI_PER_LSB +: 3]; // R2
        end
        TBI_OFS_CTL1: begin
          next_st.tb1_on  = pwdata[TBI_ON_BIT]; // R4
          next_st.tb1_per = pwdata[TBI_PER_LSB +: 3]; // R3
        end
        TBI_OFS_IRQEN: begin
          next_st.tb0_en = pwdata[TBI_ENA0_BIT];
          next_st.tb1_en = pwdata[TBI_ENA1_BIT];
          next_st.ser_en = pwdata[TBI_SERE_BIT];
          next_st.mf_en  = pwdata[TBI_MFE_BIT];
        end
        default: ;
      endcase
    end

    // global enable: service clears, return sets, plain return ignored
    if (svc) begin
      next_st.gie = 1'b0; // R7 R10
    end else if (return_from_interrupt) begin
      next_st.gie = 1'b1; // R15
    end else if (wr_en) begin
      next_st.gie = pwdata[TBI_GIE_BIT]; // R16
    end

    // tick0 flag: hardware set wins over any clear
    if (ovf0) begin
      next_st.f0 = 1'b1; // R5
    end else if (wr_flags) begin
      next_st.f0 = pwdata[TBI_FLG0_BIT]; // R13
    end else if (svc0) begin
      next_st.f0 = 1'b0; // R7
    end

    // tick1 flag
    if (ovf1) begin
      next_st.f1 = 1'b1; // R5
    end else if (wr_flags) begin
      next_st.f1 = pwdata[TBI_FLG1_BIT]; // R13
    end else if (svc1) begin
      next_st.f1 = 1'b0; // R7
    end

    // serial byte flag, never cleared by service
    if (serial_byte_done) begin
      next_st.fser = 1'b1; // R8
    end else if (wr_flags) begin
      next_st.fser = pwdata[TBI_SERF_BIT]; // R10
    end

    // multifunction flag follows an enabled serial request
    if (serial_byte_done && st.ser_en) begin
      next_st.fmf = 1'b1;
    end else if (wr_flags) begin
      next_st.fmf = pwdata[TBI_MFF_BIT];
    end else if (svcmf) begin
      next_st.fmf = 1'b0; // R10
    end

    // vector request with fixed priority tick0, tick1, multifunction
    next_st.irq_req = (pend0 || pend1 || pendmf) && !svc; // R6 R9
    if (pend0) begin
      next_st.irq_vec = TBI_VEC_TICK0;
    end else if (pend1) begin
      next_st.irq_vec = TBI_VEC_TICK1;
    end else if (pendmf) begin
      next_st.irq_vec = TBI_VEC_MF;
    end

    // wake on any rising request flag
    cur_flags     = {st.fmf, st.fser, st.f1, st.f0};
    nxt_flags     = {next_st.fmf, next_st.fser, next_st.f1, next_st.f0};
    next_st.wake  = |(nxt_flags & ~cur_flags); // R11 R12
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================================
  // outputs
  assign prdata            = st.prdata;
  assign pready            = 1'b1;
  assign pslverr           = access && !mapped;
  assign irq_req           = st.irq_req;
  assign irq_vector        = st.irq_vec;
  assign push_pc           = svc; // R14
  assign wake_request      = st.wake;
  assign global_irq_enable = st.gie;

  // =====================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_set_a: assert property (ovf0 |=> st.f0) // R5
    else $error("overflow did not set tick0 flag");
  tick_vector_a: assert property (
    st.irq_req && st.irq_vec == TBI_VEC_TICK0
    |-> $past(st.gie && st.tb0_en && st.f0 && !stack_full)) // R6
    else $error("tick0 vectored without its conditions");
  svc_clear_a: assert property (
    svc0 && !ovf0 && !wr_flags |=> !st.f0 && !st.gie) // R7
    else $error("tick0 service left flag or gie set");
  tick1_clear_a: assert property (
    svc1 && !ovf1 && !wr_flags |=> !st.f1 && !st.gie) // R7
    else $error("tick1 service left flag or gie set");
  vec_prio_a: assert property (
    st.irq_req && st.irq_vec == TBI_VEC_TICK1 |-> !$past(pend0)) // R6
    else $error("tick1 vectored over a pending tick0");
  serial_set_a: assert property (serial_byte_done |=> st.fser) // R8
    else $error("serial byte did not set serial flag");
  mf_vector_a: assert property (
    st.irq_req && st.irq_vec == TBI_VEC_MF
    |-> $past(st.gie && st.ser_en && st.mf_en && st.fmf
              && !stack_full)) // R9
    else $error("multifunction vectored without enables");
  serial_keep_a: assert property (
    svcmf && st.fser && !wr_flags |=> st.fser && !st.gie) // R10
    else $error("serial service touched serial flag");
  mf_clear_a: assert property (
    svcmf && !serial_byte_done && !wr_flags |=> !st.fmf) // R10
    else $error("service left multifunction flag set");
  wake_rise_a: assert property (!st.f0 ##1 st.f0 |-> st.wake) // R11
    else $error("rising flag gave no wake");
  wake_cause_a: assert property (
    st.wake |-> ({st.fmf, st.fser, st.f1, st.f0} &
                 ~$past({st.fmf, st.fser, st.f1, st.f0})) != 4'h0) // R11
    else $error("wake without a rising flag");
  flag_hold_a: assert property (
    st.f1 && !svc1 && !wr_flags |=> st.f1) // R13
    else $error("request flag dropped on its own");
  return_gie_a: assert property (
    return_from_interrupt && !svc |=> st.gie) // R15
    else $error("interrupt return left gie low");
  ret_hold_a: assert property (
    !return_from_interrupt && !svc && !wr_en
    |=> st.gie == $past(st.gie)) // R16
    else $error("gie changed without a cause");
  zero_bits_a: assert property (
    setup && !pwrite && paddr == TBI_OFS_CTL0
    |=> prdata[6:3] == 4'h0 && prdata[31:8] == 24'h00_0000) // R18
    else $error("unused control bits read nonzero");
  on_reset_a: assert property (
    $rose(presetn) |-> !st.tb0_on && !st.tb1_on) // R4
    else $error("time base enabled after reset");
  push_only_a: assert property (push_pc |-> st.irq_req ##1 !st.gie) // R14
    else $error("push without a presented request");

  // main scenario covers
  tick0_svc_c: cover property (svc0 ##[1:300] return_from_interrupt);
  tick1_svc_c: cover property (svc1);
  mf_svc_c:    cover property (serial_byte_done ##[1:20] svcmf);
  wake_c:      cover property (!st.gie ##1 st.wake);
  both_ovf_c:  cover property (st.f0 && st.f1);

endmodule // tbi_top
`default_nettype wire

//--- sim/tbi_top_tb.sv
// testbench: register, period, service and wake checks for tbi_top
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  bad_count++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module tbi_top_tb
  import tbi_pkg::*;
;
  // =====================================================================
  // bench signals
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sub_clock = 1'b0;
  logic        serial_byte_done;
  logic        stack_full;
  logic        irq_ack;
  logic        return_from_interrupt;
  logic        irq_req;
  tbi_vec_e    irq_vector;
  logic        push_pc;
  logic        wake_request;
  logic        global_irq_enable;
  logic [31:0] rd;
  logic        err;
  int          cyc = 0;
  int          wake_cnt = 0;
  int          wake_t = 0;
  int          sub_cnt = 0;
  int          t1;
  int          bad_count = 0;
  int          checked = 0;

  tbi_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_clock(sub_clock),
    .serial_byte_done(serial_byte_done), .stack_full(stack_full),
    .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .irq_req(irq_req), .irq_vector(irq_vector), .push_pc(push_pc),
    .wake_request(wake_request), .global_irq_enable(global_irq_enable)
  );

  // =====================================================================
  // clocks: 25 MHz system clock, sub clock at one sixth of it
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    sub_cnt <= (sub_cnt == 2) ? 0 : sub_cnt + 1;
    if (sub_cnt == 2) begin
      sub_clock <= ~sub_clock;
    end
  end

  // wake pulse log and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wake_request === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
      wake_t   <= cyc;
    end
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  // =====================================================================
  // tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one apb transfer; read data and error kept in rd and err
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    if (n == 20) begin
      bad_count++;
      stop_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex,
                        input string nm);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask

  // bounded wait for the next wake pulse
  task automatic wait_wake;
    int c;
    int n;
    c = wake_cnt;
    n = 0;
    while (wake_cnt == c && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 4000) begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic wait_req;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_req !== 1'b1 && n < 600);
    `CHK("req wait", 1'b1, irq_req)
  endtask

  // time between two time-outs of one base
  task automatic period(input logic [7:0] so, input logic [7:0] co,
                        input logic [1:0] s, input logic [2:0] k,
                        input int ex, input string nm);
    apb(1'b1, so, {30'h0000_0000, s});
    apb(1'b1, co, {24'h00_0000, 5'h10, k});
    wait_wake();
    apb(1'b1, TBI_OFS_IRQFLG, 32'h0000_0000);
    t1 = wake_t;
    wait_wake();
    `CHK(nm, ex, wake_t - t1)
    apb(1'b1, TBI_OFS_IRQFLG, 32'h0000_0000);
    apb(1'b1, co, 32'h0000_0000);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, serial_byte_done} = 5'h00;
    {stack_full, irq_ack, return_from_interrupt} = 3'h0;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // register reset values, masks, unmapped access
    rd_chk(TBI_OFS_PSC0, 32'h0000_0000, "src0 rst");
    rd_chk(TBI_OFS_PSC1, 32'h0000_0000, "src1 rst");
    rd_chk(TBI_OFS_CTL0, 32'h0000_0000, "ctl0 rst");
    rd_chk(TBI_OFS_CTL1, 32'h0000_0000, "ctl1 rst");
    apb(1'b1, TBI_OFS_PSC1, 32'h0000_00FF);
    rd_chk(TBI_OFS_PSC1, 32'h0000_0003, "src1 mask");
    apb(1'b1, TBI_OFS_CTL0, 32'h0000_00FF);
    rd_chk(TBI_OFS_CTL0, 32'h0000_0087, "ctl0 mask");
    apb(1'b1, TBI_OFS_CTL1, 32'h0000_00FF);
    rd_chk(TBI_OFS_CTL1, 32'h0000_0087, "ctl1 mask");
    apb(1'b1, TBI_OFS_CTL0, 32'h0000_0000);
    apb(1'b1, TBI_OFS_CTL1, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    $display("test registers done");
    // time-out periods per source and period field
    period(TBI_OFS_PSC0, TBI_OFS_CTL0, 2'h0, 3'h0, 256, "tb0 sys");
    period(TBI_OFS_PSC0, TBI_OFS_CTL0, 2'h1, 3'h0, 1024, "tb0 q");
    period(TBI_OFS_PSC0, TBI_OFS_CTL0, 2'h2, 3'h0, 1536, "tb0 sub");
    period(TBI_OFS_PSC0, TBI_OFS_CTL0, 2'h0, 3'h3, 2048, "tb0 k3");
    period(TBI_OFS_PSC1, TBI_OFS_CTL1, 2'h3, 3'h0, 1536, "tb1 sub");
    period(TBI_OFS_PSC1, TBI_OFS_CTL1, 2'h0, 3'h1, 512, "tb1 k1");
    $display("test periods done");
    // time base service, return, stack full, enable gating
    apb(1'b1, TBI_OFS_IRQEN, 32'h0000_0003);
    apb(1'b1, TBI_OFS_CTL0, 32'h0000_0080);
    wait_req();
    `CHK("vec tick0", TBI_VEC_TICK0, irq_vector)
    irq_ack <= 1'b1;
    @(posedge pclk);
    `CHK("push pc", 1'b1, push_pc)
    irq_ack <= 1'b0;
    @(posedge pclk);
    `CHK("gie after ack", 1'b0, global_irq_enable)
    `CHK("req after ack", 1'b0, irq_req)
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_0000, "flag after ack");
    return_from_interrupt <= 1'b1;
    @(posedge pclk);
    return_from_interrupt <= 1'b0;
    @(posedge pclk);
    `CHK("gie after ret", 1'b1, global_irq_enable)
    stack_full <= 1'b1;
    wait_wake();
    repeat (4) @(posedge pclk);
    `CHK("req stack full", 1'b0, irq_req)
    stack_full <= 1'b0;
    wait_req();
    apb(1'b1, TBI_OFS_IRQEN, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK("req masked", 1'b0, irq_req)
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_0001, "flag held");
    apb(1'b1, TBI_OFS_CTL0, 32'h0000_0000);
    apb(1'b1, TBI_OFS_IRQFLG, 32'h0000_0000);
    $display("test service done");
    // serial byte flag through the multifunction path
    apb(1'b1, TBI_OFS_IRQEN, 32'h0000_0009);
    repeat (3) @(posedge pclk);
    t1 = wake_cnt;
    serial_byte_done <= 1'b1;
    @(posedge pclk);
    serial_byte_done <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("req mf off", 1'b0, irq_req)
    `CHK("wake serial", t1 + 1, wake_cnt)
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_000C, "serial flags");
    apb(1'b1, TBI_OFS_IRQEN, 32'h0000_0019);
    wait_req();
    `CHK("vec mf", TBI_VEC_MF, irq_vector)
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_0004, "serial kept");
    `CHK("gie after mf", 1'b0, global_irq_enable)
    apb(1'b1, TBI_OFS_IRQFLG, 32'h0000_0000);
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_0000, "flags cleared");
    $display("test serial done");
    // preset flag keeps an overflow from waking
    apb(1'b1, TBI_OFS_IRQFLG, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    t1 = wake_cnt;
    apb(1'b1, TBI_OFS_PSC0, 32'h0000_0000);
    apb(1'b1, TBI_OFS_CTL0, 32'h0000_0080);
    repeat (300) @(posedge pclk);
    `CHK("no wake", t1, wake_cnt)
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_0001, "flag still set");
    $display("test wake block done");
    // tick1 vector and its service
    apb(1'b1, TBI_OFS_CTL0, 32'h0000_0000);
    apb(1'b1, TBI_OFS_IRQFLG, 32'h0000_0002);
    apb(1'b1, TBI_OFS_IRQEN, 32'h0000_0005);
    wait_req();
    `CHK("vec tick1", TBI_VEC_TICK1, irq_vector)
    irq_ack <= 1'b1;
    @(posedge pclk);
    `CHK("push pc1", 1'b1, push_pc)
    irq_ack <= 1'b0;
    @(posedge pclk);
    `CHK("gie after ack1", 1'b0, global_irq_enable)
    rd_chk(TBI_OFS_IRQFLG, 32'h0000_0000, "flag1 after ack");
    $display("test tick1 done");
    stop_test();
  end
endmodule // tbi_top_tb
`default_nettype wire
